// ---- design/pws_supervisor.sv ----
`timescale 1ns/10ps
// Summary of operation
// - Low pushbutton is a press, debounced
// - Press raises power-on before release, minimum hold
// - Keepalive low in normal run drops power-on
// - Pushbutton held 10 s in normal run drops power-on
// - Global restart command drops power-on
// - Keepalive low in normal run disables regulators, plus 1 s
// - Keepalive ignored 10 s during turn-on
// - Missing toggle pulls watchdog fault 200 ms
// - Undervoltage asserts reset after timebase delay
// - All regulators disabled drives reset low
// - Interrupt low on undervoltage, temperature, error
// - Regulator enables are active high
// - Power-on rises after 200 ms press
// - Keepalive low in normal run drops power-on after 50 ms; regulators are cut at once
// - Keepalive ignored for power-on while pushbutton held low
module pws_supervisor (
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    input  wire logic [15:0]                timing_capacitor_scale,
    input  wire logic                       pushbutton_n,
    input  wire logic                       keepalive_in,
    input  wire logic                       watchdog_kick_in,
    input  wire logic                       restart_cmd,
    input  wire logic [pws_pkg::NUM_REG-1:0] regulator_enable_in,
    input  wire pws_pkg::pws_fault_t        fault_in,
    output pws_pkg::pws_od_t                power_on_out,
    output pws_pkg::pws_od_t                watchdog_fault_out,
    output pws_pkg::pws_od_t                reset_n_out,
    output pws_pkg::pws_od_t                irq_n_out,
    output logic [pws_pkg::NUM_REG-1:0]     regulator_run
);
    import pws_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Saturating tick counter step. Saturation keeps a stuck input from
    // wrapping round and looking like a fresh event, at the cost of never
    // timing anything longer than the counter can hold
    function automatic logic [15:0] tick_step(input logic [15:0] cnt, input logic en);
        logic [15:0] res;
        res = cnt;
        if (en && cnt != 16'hffff)
            res = cnt + TK_ONE;
        return res;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic pb_n_s;
    logic keep_s;
    logic wdi_s;

    pws_sync u_sync_pb (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (pushbutton_n),
        .dout    (pb_n_s)
    );
    pws_sync u_sync_keep (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (keepalive_in),
        .dout    (keep_s)
    );
    pws_sync u_sync_wdi (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (watchdog_kick_in),
        .dout    (wdi_s)
    );

    // ------------------------------------------------------------------
    // Shared timebase
    // ------------------------------------------------------------------
    logic [31:0] pre_reg;
    logic [31:0] pre_next;
    logic        tick;
    logic [31:0] tick_len;

    // Scale 0 gives a one-cycle tick so the timebase never stalls
    assign tick_len = (timing_capacitor_scale == 16'h0000) ? 32'h0000_0001
                    : 32'(TICK_CYC_NOM) * 32'(timing_capacitor_scale) / 32'h0000_0100;
    assign tick     = (pre_reg >= tick_len - 32'h0000_0001);

    // Free-running prescaler; a scale change takes effect at once because
    // the compare is against the live length, never a stored one
    always_comb begin
        pre_next = tick ? 32'h0000_0000 : pre_reg + 32'h0000_0001;
    end

    // ------------------------------------------------------------------
    // Power-on sequencer
    // ------------------------------------------------------------------
    pws_state_t  st_reg;
    pws_state_t  st_next;
    logic [15:0] pb_cnt_reg;
    logic [15:0] pb_cnt_next;
    logic [15:0] st_cnt_reg;
    logic [15:0] st_cnt_next;
    logic [15:0] kdeb_reg;
    logic [15:0] kdeb_next;
    logic [15:0] hold_reg;
    logic [15:0] hold_next;
    logic        on_reg;
    logic        on_next;
    logic        keep_low;

    // Keepalive low only counts after the debounce time, and never
    // while the button is held: a held button can mean a user override
    assign keep_low = (kdeb_reg >= KEEP_DEB_TK) && pb_n_s;

    always_comb begin
        st_next     = st_reg;
        on_next     = on_reg;
        st_cnt_next = tick_step(st_cnt_reg, tick);
        // Press-duration counter, cleared on release
        pb_cnt_next = pb_n_s ? TK_ZERO : tick_step(pb_cnt_reg, tick);
        kdeb_next   = keep_s ? TK_ZERO : tick_step(kdeb_reg, tick);
        // Regulator hold-off reloads while keepalive low, then runs down
        if (!keep_s)
            hold_next = HOLD_OFF_TK;
        else if (tick && hold_reg != TK_ZERO)
            hold_next = hold_reg - TK_ONE;
        else
            hold_next = hold_reg;
        case (st_reg)
            PWS_OFF: begin
                if (!pb_n_s && pb_cnt_reg >= PB_ON_TK) begin
                    st_next     = PWS_PRESS;
                    on_next     = 1'b1;
                    st_cnt_next = TK_ZERO;
                end
            end
            PWS_PRESS: begin
                // Wait for release so a long first press is not read as off
                if (pb_n_s) begin
                    st_next = PWS_WAIT;
                end
            end
            PWS_WAIT: begin
                // Blanking: keepalive low is not acted on here
                if (keep_s && st_cnt_reg >= ON_MIN_TK) begin
                    st_next = PWS_RUN;
                end else if (st_cnt_reg >= KEEP_WAIT_TK) begin
                    st_next = PWS_DOWN;
                    on_next = 1'b0;
                end
            end
            PWS_RUN: begin
                if (keep_low || pb_cnt_reg >= PB_OFF_TK) begin
                    st_next = PWS_DOWN;
                    on_next = 1'b0;
                end
            end
            PWS_DOWN: begin
                // Re-arm only after the button is released
                if (pb_n_s) begin
                    st_next = PWS_OFF;
                end
            end
            default: begin
                st_next = PWS_OFF;
                on_next = 1'b0;
            end
        endcase
        // Restart is applied last so it overrides every state decision except in OFF
        if (restart_cmd && st_reg != PWS_OFF) begin
            st_next = PWS_DOWN;
            on_next = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    logic        wdi_d_reg;
    logic        wdi_d_next;
    logic [15:0] wd_cnt_reg;
    logic [15:0] wd_cnt_next;
    logic [15:0] wdo_cnt_reg;
    logic [15:0] wdo_cnt_next;

    // Any synchronised edge restarts the period; a missed period loads the
    // fault stretch. The stretch is frozen on the tick that reloads it, so
    // a hung host sees back-to-back fault pulses rather than a merged one
    always_comb begin
        wdi_d_next   = wdi_s;
        wd_cnt_next  = wd_cnt_reg;
        wdo_cnt_next = wdo_cnt_reg;
        if (wdi_s != wdi_d_reg) begin
            wd_cnt_next = TK_ZERO;
        end else if (tick) begin
            if (wd_cnt_reg >= WDG_PERIOD_TK - TK_ONE) begin
                wd_cnt_next  = TK_ZERO;
                wdo_cnt_next = WDG_LOW_TK;
            end else begin
                wd_cnt_next = wd_cnt_reg + TK_ONE;
            end
        end
        if (tick && wdo_cnt_reg != TK_ZERO && wd_cnt_reg < WDG_PERIOD_TK - TK_ONE)
            wdo_cnt_next = wdo_cnt_reg - TK_ONE;
    end

    // ------------------------------------------------------------------
    // Reset and interrupt
    // ------------------------------------------------------------------
    logic [NUM_REG-1:0] uv_live;
    logic               any_en;
    logic [15:0]        rst_cnt_reg;
    logic [15:0]        rst_cnt_next;
    logic [15:0]        irq_cnt_reg;
    logic [15:0]        irq_cnt_next;
    logic               irq_cond;

    // Masked or switched-off regulators cannot hold reset; a rail that is
    // disabled on purpose will naturally sit below its set point
    assign any_en   = |regulator_run;
    assign uv_live  = fault_in.uv & ~fault_in.uv_mask & regulator_run;
    assign irq_cond = (|uv_live) || fault_in.temp_alarm || fault_in.error;

    always_comb begin
        // Undervoltage must persist for the assertion delay
        if (uv_live == '0)
            rst_cnt_next = TK_ZERO;
        else if (tick && rst_cnt_reg < RST_DLY_TK)
            rst_cnt_next = rst_cnt_reg + TK_ONE;
        else
            rst_cnt_next = rst_cnt_reg;
        // Stretch the interrupt to its minimum pulse width
        if (irq_cond)
            irq_cnt_next = IRQ_PW_TK;
        else if (tick && irq_cnt_reg != TK_ZERO)
            irq_cnt_next = irq_cnt_reg - TK_ONE;
        else
            irq_cnt_next = irq_cnt_reg;
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    // Edge memory resets to the synchroniser idle level, so no false kick
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pre_reg     <= 32'h0000_0000;
            st_reg      <= PWS_OFF;
            on_reg      <= 1'b0;
            pb_cnt_reg  <= 16'h0000;
            st_cnt_reg  <= 16'h0000;
            kdeb_reg    <= 16'h0000;
            hold_reg    <= 16'h0000;
            wdi_d_reg   <= 1'b1;
            wd_cnt_reg  <= 16'h0000;
            wdo_cnt_reg <= 16'h0000;
            rst_cnt_reg <= 16'h0000;
            irq_cnt_reg <= 16'h0000;
        end else begin
            pre_reg     <= pre_next;
            st_reg      <= st_next;
            on_reg      <= on_next;
            pb_cnt_reg  <= pb_cnt_next;
            st_cnt_reg  <= st_cnt_next;
            kdeb_reg    <= kdeb_next;
            hold_reg    <= hold_next;
            wdi_d_reg   <= wdi_d_next;
            wd_cnt_reg  <= wd_cnt_next;
            wdo_cnt_reg <= wdo_cnt_next;
            rst_cnt_reg <= rst_cnt_next;
            irq_cnt_reg <= irq_cnt_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Keepalive gating is applied only after the blanking window, so the
    // host may still be booting while regulators come up
    logic kill_gate;
    assign kill_gate = (st_reg == PWS_RUN) && (!keep_s || hold_reg != TK_ZERO);
    // Limitation: outside RUN the enables pass straight through, so a host
    // that drops keepalive during the blanking window keeps its rails

    // Regulators stay off in RUN while keepalive is low and during hold-off
    assign regulator_run = kill_gate ? '0 : regulator_enable_in;

    // Open-drain: enable low drives the pin low; high releases it
    assign power_on_out.out       = 1'b0;
    assign power_on_out.oe_n      = on_reg;
    assign watchdog_fault_out.out = 1'b0;
    assign watchdog_fault_out.oe_n = (wdo_cnt_reg == TK_ZERO);
    assign reset_n_out.out        = 1'b0;
    assign reset_n_out.oe_n       = any_en && (rst_cnt_reg < RST_DLY_TK);
    assign irq_n_out.out          = 1'b0;
    assign irq_n_out.oe_n         = (irq_cnt_reg == TK_ZERO);
endmodule

// ---- design/pws_pkg.sv ----
package pws_pkg;

    // ------------------------------------------------------------------
    // Clock and timebase
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 20_000_000;
    // Tick period at nominal timing capacitor scale, in microseconds
    localparam int unsigned TICK_US         = 1000;
    localparam int unsigned TICK_CYC_NOM    = (CLK_HZ / 1_000_000) * TICK_US;

    // ------------------------------------------------------------------
    // Supervisory intervals, in milliseconds as printed
    // ------------------------------------------------------------------
    localparam int unsigned PB_ON_MS        = 200;
    localparam int unsigned PB_OFF_MS       = 10_000;
    localparam int unsigned KEEP_WAIT_MS    = 10_000;
    localparam int unsigned KEEP_DEB_MS     = 50;
    localparam int unsigned HOLD_OFF_MS     = 1000;
    localparam int unsigned WDG_PERIOD_MS   = 1500;
    localparam int unsigned WDG_LOW_MS      = 200;
    localparam int unsigned RST_DLY_MS      = 230;
    localparam int unsigned IRQ_PW_MS       = 50;
    localparam int unsigned ON_MIN_MS       = 200;

    // Intervals in timebase ticks (one tick per millisecond at nominal scale)
    localparam logic [15:0] PB_ON_TK        = 16'(PB_ON_MS * 1000 / TICK_US);
    localparam logic [15:0] PB_OFF_TK       = 16'(PB_OFF_MS * 1000 / TICK_US);
    localparam logic [15:0] KEEP_WAIT_TK    = 16'(KEEP_WAIT_MS * 1000 / TICK_US);
    localparam logic [15:0] KEEP_DEB_TK     = 16'(KEEP_DEB_MS * 1000 / TICK_US);
    localparam logic [15:0] HOLD_OFF_TK     = 16'(HOLD_OFF_MS * 1000 / TICK_US);
    localparam logic [15:0] WDG_PERIOD_TK   = 16'(WDG_PERIOD_MS * 1000 / TICK_US);
    localparam logic [15:0] WDG_LOW_TK      = 16'(WDG_LOW_MS * 1000 / TICK_US);
    localparam logic [15:0] RST_DLY_TK      = 16'(RST_DLY_MS * 1000 / TICK_US);
    localparam logic [15:0] IRQ_PW_TK       = 16'(IRQ_PW_MS * 1000 / TICK_US);
    localparam logic [15:0] ON_MIN_TK       = 16'(ON_MIN_MS * 1000 / TICK_US);

    localparam int unsigned NUM_REG         = 8;
    localparam logic [15:0] TK_ZERO         = 16'h0000;
    localparam logic [15:0] TK_ONE          = 16'h0001;

    // Power-on sequencer states, Gray coded along off -> press -> wait -> run
    typedef enum logic [2:0] {
        PWS_OFF   = 3'b000,
        PWS_PRESS = 3'b001,
        PWS_WAIT  = 3'b011,
        PWS_RUN   = 3'b010,
        PWS_DOWN  = 3'b110
    } pws_state_t;

    // Fault inputs that feed the interrupt output
    typedef struct packed {
        logic                   temp_alarm;
        logic                   error;
        logic [NUM_REG-1:0]     uv;
        logic [NUM_REG-1:0]     uv_mask;
    } pws_fault_t;

    // Open-drain pin: level driven and enable (low while driving low)
    typedef struct packed {
        logic                   out;
        logic                   oe_n;
    } pws_od_t;

endpackage

// ---- design/pws_sync.sv ----
`timescale 1ns/10ps
// Three-stage synchroniser; output changes once stages two and three agree
module pws_sync (
    input  wire logic   sys_clk,
    input  wire logic   rst,
    input  wire logic   din,
    output logic        dout
);
    import pws_pkg::*;

    logic [2:0] sh_reg;
    logic [2:0] sh_next;
    logic       out_reg;
    logic       out_next;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        sh_next  = {sh_reg[1:0], din};
        out_next = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : out_reg;
    end

    // Resets to the idle (high) level of the active-low pins it serves
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sh_reg  <= 3'h7;
            out_reg <= 1'b1;
        end else begin
            sh_reg  <= sh_next;
            out_reg <= out_next;
        end
    end

    assign dout = out_reg;
endmodule

// ---- tb/pws_host_model.sv ----
`timescale 1ns/10ps
// ----
// Host stand-in
// ----
module pws_host_model (
    input  wire logic sys_clk,
    input  wire logic power_on_pin,
    input  wire logic keep_en,
    input  wire logic kick_en,
    output logic      keepalive_in,
    output logic      watchdog_kick_in
);
    logic [9:0] kick_cnt = 10'h000;
    logic       kick_reg = 1'b0;

    // Keepalive only follows a live power-on pin, as a real host would
    assign keepalive_in = keep_en & power_on_pin;

    // Toggle every 1024 cycles, well inside the watchdog period
    assign watchdog_kick_in = kick_reg;
    always @(negedge sys_clk) begin
        kick_cnt <= kick_cnt + 10'h001;
        if (kick_en && kick_cnt == 10'h000) kick_reg <= ~kick_reg;
    end
endmodule

// ---- tb/pws_supervisor_monitor.sv ----
`timescale 1ns/10ps
// ----
// Port checker
// ----
module pws_supervisor_monitor (
    input wire logic                        sys_clk,
    input wire logic                        rst,
    input wire logic                        pushbutton_n,
    input wire logic                        watchdog_kick_in,
    input wire logic                        restart_cmd,
    input wire logic [pws_pkg::NUM_REG-1:0] regulator_enable_in,
    input wire pws_pkg::pws_fault_t         fault_in,
    input wire pws_pkg::pws_od_t            power_on_out,
    input wire pws_pkg::pws_od_t            watchdog_fault_out,
    input wire pws_pkg::pws_od_t            reset_n_out,
    input wire pws_pkg::pws_od_t            irq_n_out,
    input wire logic [pws_pkg::NUM_REG-1:0] regulator_run
);
    import pws_pkg::*;
    logic [15:0] kick_age_reg, kick_age_next, uv_age_reg, uv_age_next;
    logic        kick_prev_reg;

    // Cycle ages; a tick is never shorter than a cycle, so ages bound tick counts
    always_comb begin
        kick_age_next = (watchdog_kick_in != kick_prev_reg) ? 16'h0000 :
                        kick_age_reg + {15'h0000, kick_age_reg != 16'hffff};
        uv_age_next   = ((fault_in.uv & ~fault_in.uv_mask & regulator_run) == '0) ? 16'h0000 :
                        uv_age_reg + {15'h0000, uv_age_reg != 16'hffff};
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            kick_age_reg  <= 16'h0000;
            uv_age_reg    <= 16'h0000;
            kick_prev_reg <= 1'b0;
        end else begin
            kick_age_reg  <= kick_age_next;
            uv_age_reg    <= uv_age_next;
            kick_prev_reg <= watchdog_kick_in;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_all_off_reset: assert property ((regulator_run == '0) |-> !reset_n_out.oe_n)
        else $error("reset released with all regulators off");
    a_run_needs_enable: assert property ((regulator_run != '0) |-> regulator_run == regulator_enable_in)
        else $error("regulator runs without its enable");
    a_on_after_press: assert property ($rose(power_on_out.oe_n) |->
        $past(pushbutton_n, 5) == 1'b0 && $past(pushbutton_n, 150) == 1'b0)
        else $error("power-on without a held press");
    a_restart_drops: assert property (restart_cmd && power_on_out.oe_n |-> ##[1:3] !power_on_out.oe_n)
        else $error("restart did not drop power-on");
    a_wdg_low_span: assert property ($fell(watchdog_fault_out.oe_n) |-> !watchdog_fault_out.oe_n [*8])
        else $error("watchdog fault pulse too short");
    a_wdg_needs_idle: assert property ($fell(watchdog_fault_out.oe_n) |-> kick_age_reg >= 16'd1500)
        else $error("watchdog fault despite recent kick");
    a_irq_on_temp: assert property ($rose(fault_in.temp_alarm) |-> ##[0:4] !irq_n_out.oe_n)
        else $error("interrupt missed temperature alarm");
    a_irq_stretch: assert property ($fell(irq_n_out.oe_n) |-> !irq_n_out.oe_n [*8])
        else $error("interrupt pulse too short");
    a_uv_delay: assert property (!reset_n_out.oe_n && regulator_run != '0 |-> uv_age_reg >= 16'd230)
        else $error("reset asserted before undervoltage delay");
endmodule

bind pws_supervisor pws_supervisor_monitor pws_supervisor_monitor_i (
    .sys_clk(sys_clk), .rst(rst), .pushbutton_n(pushbutton_n),
    .watchdog_kick_in(watchdog_kick_in), .restart_cmd(restart_cmd),
    .regulator_enable_in(regulator_enable_in), .fault_in(fault_in),
    .power_on_out(power_on_out), .watchdog_fault_out(watchdog_fault_out),
    .reset_n_out(reset_n_out), .irq_n_out(irq_n_out), .regulator_run(regulator_run));

// ---- tb/test_pushbutton_watchdog_supervisor.sv ----
`timescale 1ns/10ps
module test_pushbutton_watchdog_supervisor;
    import pws_pkg::*;
    logic               sys_clk = 1'b0;
    logic               rst = 1'b1;
    logic [15:0]        scale = 16'h0000;
    logic               pushbutton_n = 1'b1;
    logic               restart_cmd = 1'b0;
    logic               keep_en = 1'b0;
    logic               kick_en = 1'b1;
    logic [NUM_REG-1:0] enables = 8'h00;
    pws_fault_t         fault = '0;
    pws_od_t            power_on_out, watchdog_fault_out, reset_n_out, irq_n_out;
    logic [NUM_REG-1:0] regulator_run;
    logic               keepalive_in, watchdog_kick_in, power_pin;
    int                 fail_count = 0;
    int                 cmp_count = 0;

    // 20 MHz clock; open-drain power pin has a pull-up
    always #25 sys_clk = ~sys_clk;
    assign power_pin = power_on_out.oe_n ? 1'b1 : power_on_out.out;

    pws_supervisor pws_supervisor_i (.sys_clk(sys_clk), .rst(rst),
        .timing_capacitor_scale(scale), .pushbutton_n(pushbutton_n),
        .keepalive_in(keepalive_in), .watchdog_kick_in(watchdog_kick_in),
        .restart_cmd(restart_cmd), .regulator_enable_in(enables), .fault_in(fault),
        .power_on_out(power_on_out), .watchdog_fault_out(watchdog_fault_out),
        .reset_n_out(reset_n_out), .irq_n_out(irq_n_out), .regulator_run(regulator_run));
    pws_host_model pws_host_model_i (.sys_clk(sys_clk), .power_on_pin(power_pin),
        .keep_en(keep_en), .kick_en(kick_en), .keepalive_in(keepalive_in),
        .watchdog_kick_in(watchdog_kick_in));

    // ----
    // Shared tasks
    // ----
    task automatic check(input string name, input logic seen, input logic exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %b, seen %b", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n); repeat (n) @(negedge sys_clk); endtask
    task automatic do_reset; rst = 1'b1; cyc(3); rst = 1'b0; cyc(2); endtask
    task automatic power_up;
        do_reset;
        keep_en = 1'b1;
        pushbutton_n = 1'b0; cyc(260); pushbutton_n = 1'b1; cyc(400);
        check("power on", power_pin, 1'b1);
    endtask
    task automatic results;
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_idle;
        do_reset;
        check("power idle", power_pin, 1'b0);
        check("reset all off", reset_n_out.oe_n, 1'b0);
        enables = 8'h5a; cyc(2);
        check("run follows enable", regulator_run === 8'h5a, 1'b1);
        check("reset released", reset_n_out.oe_n, 1'b1);
    endtask
    task automatic t_press;
        scale = 16'h0001; do_reset;
        pushbutton_n = 1'b0; cyc(15000);
        check("slow tick early", power_pin, 1'b0);
        cyc(1000); check("slow tick on", power_pin, 1'b1);
        pushbutton_n = 1'b1; scale = 16'h0000; do_reset;
        pushbutton_n = 1'b0; cyc(150); pushbutton_n = 1'b1; cyc(100);
        check("short press", power_pin, 1'b0);
        pushbutton_n = 1'b0; cyc(210);
        check("long press", power_pin, 1'b1);
        pushbutton_n = 1'b1; cyc(150);
        check("min on", power_pin, 1'b1);
    endtask
    task automatic t_timeout;
        do_reset; keep_en = 1'b0;
        pushbutton_n = 1'b0; cyc(210); pushbutton_n = 1'b1; cyc(9500);
        check("blanking", power_pin, 1'b1);
        cyc(700); check("no keepalive", power_pin, 1'b0);
    endtask
    task automatic t_keep;
        enables = 8'h3c; power_up;
        keep_en = 1'b0; cyc(30);
        check("keep glitch", power_pin, 1'b1);
        check("reg off", regulator_run === 8'h00, 1'b1);
        keep_en = 1'b1; cyc(500);
        check("reg hold off", regulator_run === 8'h00, 1'b1);
        cyc(600); check("reg back", regulator_run === 8'h3c, 1'b1);
        pushbutton_n = 1'b0; keep_en = 1'b0; cyc(200);
        check("press masks keep", power_pin, 1'b1);
        keep_en = 1'b1; cyc(10); pushbutton_n = 1'b1; cyc(1100);
        keep_en = 1'b0; cyc(40);
        check("keep debounce", power_pin, 1'b1);
        cyc(30); check("keep drop", power_pin, 1'b0);
    endtask
    task automatic t_hold;
        power_up; pushbutton_n = 1'b0; cyc(9800);
        check("hold early", power_pin, 1'b1);
        cyc(300); check("hold off", power_pin, 1'b0);
        pushbutton_n = 1'b1;
        power_up; restart_cmd = 1'b1; cyc(1); restart_cmd = 1'b0; cyc(3);
        check("restart", power_pin, 1'b0);
    endtask
    task automatic t_wdg;
        int n;
        do_reset; cyc(3000);
        check("kicked", watchdog_fault_out.oe_n, 1'b1);
        kick_en = 1'b0; n = 0;
        while (watchdog_fault_out.oe_n === 1'b1 && n < 2600) begin cyc(1); n++; end
        check("fault seen", n > 400 && n < 2600, 1'b1);
        cyc(190); check("fault held", watchdog_fault_out.oe_n, 1'b0);
        cyc(20); check("fault ends", watchdog_fault_out.oe_n, 1'b1);
        kick_en = 1'b1;
    endtask
    task automatic t_faults;
        do_reset; enables = 8'h01; fault.uv = 8'h01; cyc(200);
        check("uv early", reset_n_out.oe_n, 1'b1);
        cyc(40); check("uv reset", reset_n_out.oe_n, 1'b0);
        check("uv irq", irq_n_out.oe_n, 1'b0);
        fault.uv_mask = 8'h01; cyc(3);
        check("uv masked", reset_n_out.oe_n, 1'b1);
        fault = '0; cyc(60);
        for (int i = 0; i < 2; i++) begin
            fault.temp_alarm = (i == 0); fault.error = (i == 1); cyc(3);
            check("irq low", irq_n_out.oe_n, 1'b0);
            fault = '0; cyc(40);
            check("irq stretch", irq_n_out.oe_n, 1'b0);
            cyc(20); check("irq clear", irq_n_out.oe_n, 1'b1);
        end
    endtask

    // Main sequence, with the watchdog hang before the fault checks
    initial begin
        t_idle; t_press; t_timeout; t_keep; t_hold; t_wdg; t_faults;
        results;
    end
    initial begin
        #(80_000 * 50);
        fail_count++;
        results;
    end
endmodule
